// *** design/dac_front_pkg.sv ***
package dac_front_pkg;
  localparam int CLK_NS        = 100;
  localparam int LOAD_MAX_NS   = 2000;
  localparam int LOAD_MAX_CYC  = LOAD_MAX_NS / CLK_NS;
  localparam int GPI_MIN_NS    = 2000;
  localparam int GPI_MIN_CYC   = (GPI_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_GAP_NS  = 1000;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int I2C_STD_KBPS  = 100;
  localparam int I2C_FAST_KBPS = 400;
  localparam int I2C_FMP_KBPS  = 1000;
  localparam int SPI_WR_MAX_KHZ = 50000;
  // readback clock ceilings in kHz: 2500 and 1250
  localparam logic [11:0] RDBK_FAST_KHZ = 12'h9C4;
  localparam logic [11:0] RDBK_SLOW_KHZ = 12'h4E2;

  localparam int NREG = 9;
  localparam int AW   = 4;
  localparam logic [3:0] REG_DAC0   = 4'h0;
  localparam logic [3:0] REG_DAC1   = 4'h1;
  localparam logic [3:0] REG_COMMON = 4'h2;
  localparam logic [3:0] REG_GPIO   = 4'h3;
  localparam logic [3:0] REG_WAVE   = 4'h4;
  localparam logic [3:0] REG_CMP    = 4'h5;
  localparam logic [3:0] REG_MRG_HI = 4'h6;
  localparam logic [3:0] REG_MRG_LO = 4'h7;
  localparam logic [3:0] REG_TRIG   = 4'h8;
  localparam logic [3:0] REG_STAT   = 4'h9;

  localparam int CM_PDN_LSB  = 0;
  localparam int CM_IOUT0    = 2;
  localparam int CM_IOUT1    = 3;
  localparam int GP_ROLE_LSB = 0;
  localparam int GP_LD_ALL   = 3;
  localparam int GP_LD_CH    = 4;
  localparam int GP_FAST     = 5;
  localparam int WV_SEL_LSB  = 0;
  localparam int WV_EN0      = 2;
  localparam int WV_EN1      = 3;
  localparam int WV_RATE_LSB = 8;
  localparam int CP_LATCH    = 4;
  localparam int CP_WIN      = 5;
  localparam int CP_DUMP     = 6;
  localparam int TR_STORE    = 0;
  localparam int TR_RELOAD   = 1;
  localparam int TR_CLRLAT   = 2;

  localparam logic [1:0] PDN_HIZ  = 2'h0;
  localparam logic [1:0] PDN_10K  = 2'h1;
  localparam logic [1:0] PDN_100K = 2'h2;
  localparam logic [1:0] WAVE_SIN = 2'h0;
  localparam logic [1:0] WAVE_COS = 2'h1;
  localparam logic [1:0] WAVE_TRI = 2'h2;
  localparam logic [11:0] WAVE_STEP = 12'h010;

  localparam logic [15:0] RST_COMMON = 16'h0000;
  localparam logic [15:0] RST_GPIO   = 16'h0008;
  localparam logic [NREG-1:0][15:0] REG_RESET = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    RST_GPIO, RST_COMMON, 16'h0000, 16'h0000};

  localparam logic [7:0] PMB_OPERATION = 8'h01;
  localparam int OP_ON_BIT  = 7;
  localparam int OP_MRG_LSB = 4;
  // arbitrary base for the four target addresses
  localparam logic [6:0] I2C_ADDR_BASE = 7'h48;

  typedef enum logic [2:0] {
    ROLE_LOAD, ROLE_SHUTDOWN, ROLE_STATUS, ROLE_FAULT_STORE,
    ROLE_RESET, ROLE_PROTECT, ROLE_READBACK
  } gpio_role_e;

  typedef enum logic [1:0] {ST_POR, ST_LOAD, ST_IDLE, ST_STORE} nvm_state_e;

  typedef struct packed {
    logic          valid;
    logic          write;
    logic          spi;
    logic          pmbus;
    logic [AW-1:0] addr;
    logic [15:0]   data;
  } hostReq_s;

  typedef struct packed {
    logic        ack;
    logic        refused;
    logic [15:0] rdata;
  } hostAns_s;
endpackage

// *** design/dac_host_port_and_gpio_load.sv ***
`timescale 1ns/10ps
// Functional notes
// - load trigger fall applies pending codes within 2 us
// - fast readout limits readback clock to 2.5 MHz
// - i2c target runs at 100 kbps, 400 kbps and 1 Mbps
// - i2c address comes from address-select pin level, four choices
// - spi is 3-wire write-only by default, up to 50 MHz
// - pin is readback output only when stored so; enables spi reads
// - pin roles: load, shutdown, status, fault store, reset, protect
// - load trigger updates one chosen channel or all channels
// - after reset registers hold factory or stored values
// - power-down defaults to hi-z, or 10k or 100k pull-down
// - each channel independently voltage or current output
// - waveform mode gives sine, cosine, triangle and sawtooth
// - comparator offers hysteresis, latch, window and fault store
// - i2c accepts pmbus output on/off and margin high/low
// - lock to first successful protocol, ignore the other later
// - store trigger bit clears itself once programming starts
// - host accesses blocked while store or reload runs
module dac_host_port_and_gpio_load
  import dac_front_pkg::*;
#(
  parameter int GPI_MIN = GPI_MIN_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire hostReq_s             hostReq,
  output hostAns_s                  hostAns,
  input  wire logic                 gpioPinIn,
  output logic                      gpioPinOut,
  output logic                      gpioPinOeN,
  input  wire logic [1:0]           addrSelLevel,
  input  wire logic [1:0]           cmpRaw,
  input  wire logic                 rdbkBit,
  input  wire logic [NREG-1:0][15:0] nvmImage,
  input  wire logic                 nvmImageValid,
  input  wire logic                 nvmDone,
  output logic                      nvmStoreReq,
  output logic                      nvmReloadReq,
  output logic [NREG-1:0][15:0]     regImage,
  output logic [11:0]               dacCode0,
  output logic [11:0]               dacCode1,
  output logic                      outputsOff,
  output logic [1:0]                cmpOut,
  output logic [1:0]                faultLatched,
  output logic                      busy,
  output logic                      protoLocked,
  output logic                      protoSpi,
  output logic [6:0]                i2cAddr,
  output logic [11:0]               rdbkMaxKhz
);
  nvm_state_e              state_r, state_nxt;
  logic [NREG-1:0][15:0]   regs_r, regs_nxt;
  gpio_role_e              storedRole_r, storedRole_nxt;
  logic [1:0][11:0]        latch_r, latch_nxt;
  logic [1:0][11:0]        code_r, code_nxt;
  logic [1:0]              mrg_r, mrg_nxt;
  logic                    opOn_r, opOn_nxt, off_r, off_nxt;
  logic [1:0]              fLat_r, fLat_nxt, cmpO_r, cmpO_nxt;
  logic                    stReq_r, stReq_nxt, rlReq_r, rlReq_nxt;
  logic                    lock_r, lock_nxt, spi_r, spi_nxt;
  logic [6:0]              addr_r, addr_nxt;
  logic [11:0]             khz_r, khz_nxt;
  hostAns_s                ans_r, ans_nxt;
  logic                    pinOeN_r, pinOeN_nxt;
  logic [7:0]              wDiv_r, wDiv_nxt;
  logic [11:0]             phase_r, phase_nxt;
  logic [1:0]              addrS1_r, addrS2_r, cmpS1_r, cmpS2_r;
  logic                    gpioLevel, gpioFall;
  gpio_role_e              role;
  logic [1:0]              cmpRes, wSel;
  logic                    rbOn, hostDrop, hostBlk, ldAll;
  logic [11:0]             wSample;

  // same filter serves level roles and the edge-triggered ones
  pin_qualifier #(.MIN_CYC(GPI_MIN)) u_gpio_qual (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (gpioPinIn),
    .level   (gpioLevel),
    .fall    (gpioFall)
  );

  function automatic logic [11:0] wave_sample(input logic [1:0] sel,
                                              input logic [11:0] ph);
    logic [11:0] q;
    logic [10:0] h;
    logic [11:0] c;
    logic [22:0] prod;
    logic [11:0] half;
    q    = (sel == WAVE_COS) ? ph + 12'h400 : ph;
    h    = q[10:0];
    c    = 12'h800 - {1'b0, h};
    // parabola per half period stands in for a sine table
    prod = h * c;
    half = prod[21:10];
    if (sel == WAVE_TRI) begin
      wave_sample = ph[11] ? ~{ph[10:0], 1'b0} : {ph[10:0], 1'b0};
    end else if (sel == WAVE_SIN || sel == WAVE_COS) begin
      wave_sample = q[11] ? 12'h800 - half : 12'h800 + half;
    end else begin
      wave_sample = ph;
    end
  endfunction

  assign role    = gpio_role_e'(regs_r[REG_GPIO][GP_ROLE_LSB +: 3]);
  assign ldAll   = regs_r[REG_GPIO][GP_LD_ALL];
  assign wSel    = regs_r[REG_WAVE][WV_SEL_LSB +: 2];
  assign wSample = wave_sample(wSel, phase_r);
  // readback only from the role held in persistent storage
  assign rbOn    = (storedRole_r == ROLE_READBACK) && (role == ROLE_READBACK);
  assign hostDrop = lock_r && (hostReq.spi != spi_r);
  assign hostBlk  = (state_r != ST_IDLE);

  always_comb begin
    cmpRes[1] = cmpS2_r[1];
    cmpRes[0] = regs_r[REG_CMP][CP_WIN] ? (cmpS2_r[0] & ~cmpS2_r[1])
                                        : cmpS2_r[0];
  end

  always_comb begin
    state_nxt      = state_r;
    regs_nxt       = regs_r;
    storedRole_nxt = storedRole_r;
    latch_nxt      = latch_r;
    mrg_nxt        = mrg_r;
    opOn_nxt       = opOn_r;
    fLat_nxt       = fLat_r;
    stReq_nxt      = 1'b0;
    rlReq_nxt      = 1'b0;
    lock_nxt       = lock_r;
    spi_nxt        = spi_r;
    addr_nxt       = addr_r;
    ans_nxt        = '0;
    wDiv_nxt       = wDiv_r;
    phase_nxt      = phase_r;

    // comparator latch: new trip wins over a clear in the same cycle
    if (regs_r[REG_TRIG][TR_CLRLAT]) begin
      fLat_nxt = '0;
      regs_nxt[REG_TRIG][TR_CLRLAT] = 1'b0;
    end
    if (regs_r[REG_CMP][CP_LATCH]) begin
      fLat_nxt = fLat_nxt | cmpRes;
    end

    unique case (state_r)
      ST_POR: begin
        rlReq_nxt = 1'b1;
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (nvmDone) begin
          regs_nxt = nvmImageValid ? nvmImage : REG_RESET;
          storedRole_nxt = nvmImageValid ?
            gpio_role_e'(nvmImage[REG_GPIO][GP_ROLE_LSB +: 3]) : ROLE_LOAD;
          addr_nxt  = I2C_ADDR_BASE + {5'h00, addrS2_r};
          state_nxt = ST_IDLE;
        end
      end
      ST_STORE: begin
        if (nvmDone) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (regs_r[REG_TRIG][TR_STORE]
            || (gpioFall && role == ROLE_FAULT_STORE)
            || (regs_r[REG_CMP][CP_DUMP] && |(fLat_nxt & ~fLat_r))) begin
          stReq_nxt = 1'b1;
          regs_nxt[REG_TRIG][TR_STORE] = 1'b0;
          storedRole_nxt = role;
          state_nxt = ST_STORE;
        end else if (regs_r[REG_TRIG][TR_RELOAD] || (gpioFall && role == ROLE_RESET)) begin
          rlReq_nxt = 1'b1;
          regs_nxt[REG_TRIG][TR_RELOAD] = 1'b0;
          state_nxt = ST_LOAD;
        end
      end
    endcase

    // with the load role, pending codes move to the outputs only on a qualified fall; other roles pass them straight through
    if (role != ROLE_LOAD) begin
      latch_nxt[0] = regs_r[REG_DAC0][11:0];
      latch_nxt[1] = regs_r[REG_DAC1][11:0];
    end else if (gpioFall) begin
      if (ldAll || !regs_r[REG_GPIO][GP_LD_CH]) begin
        latch_nxt[0] = regs_r[REG_DAC0][11:0];
      end
      if (ldAll || regs_r[REG_GPIO][GP_LD_CH]) begin
        latch_nxt[1] = regs_r[REG_DAC1][11:0];
      end
    end

    if (gpioFall && role == ROLE_PROTECT) begin
      opOn_nxt = 1'b0;
    end

    if (wDiv_r >= regs_r[REG_WAVE][WV_RATE_LSB +: 8]) begin
      wDiv_nxt  = 8'h00;
      phase_nxt = phase_r + WAVE_STEP;
    end else begin
      wDiv_nxt = wDiv_r + 8'h01;
    end

    // a request from the other protocol after lock gets no answer
    if (hostReq.valid && !hostDrop) begin
      if (hostBlk
          || (!hostReq.write && hostReq.spi && !rbOn)
          || (hostReq.pmbus && hostReq.spi)) begin
        ans_nxt.refused = 1'b1;
      end else begin
        ans_nxt.ack = 1'b1;
        if (!lock_r) begin
          lock_nxt = 1'b1;
          spi_nxt  = hostReq.spi;
        end
        if (hostReq.pmbus) begin
          if (hostReq.data[15:8] == PMB_OPERATION) begin
            opOn_nxt = hostReq.data[OP_ON_BIT];
            mrg_nxt  = hostReq.data[OP_MRG_LSB +: 2];
          end
        end else if (hostReq.write) begin
          if (hostReq.addr < AW'(NREG)) begin
            regs_nxt[hostReq.addr] = hostReq.data;
            if (hostReq.addr == REG_TRIG) begin
              regs_nxt[REG_TRIG] = regs_nxt[REG_TRIG] | hostReq.data;
            end
          end
        end else if (hostReq.addr == REG_STAT) begin
          ans_nxt.rdata = {8'h00, fLat_r, gpioLevel, rbOn, opOn_r, hostBlk, spi_r, lock_r};
        end else if (hostReq.addr < AW'(NREG)) begin
          ans_nxt.rdata = regs_r[hostReq.addr];
        end
      end
    end
  end

  always_comb begin
    // per-channel source: waveform, then margin, then latched code
    for (int ch = 0; ch < 2; ch++) begin
      if (regs_r[REG_WAVE][WV_EN0 + ch]) begin
        code_nxt[ch] = wSample;
      end else if (mrg_r == 2'h1) begin
        code_nxt[ch] = regs_r[REG_MRG_LO][11:0];
      end else if (mrg_r == 2'h2) begin
        code_nxt[ch] = regs_r[REG_MRG_HI][11:0];
      end else begin
        code_nxt[ch] = latch_r[ch];
      end
    end
    off_nxt  = !opOn_r || (role == ROLE_SHUTDOWN && !gpioLevel);
    cmpO_nxt = regs_r[REG_CMP][CP_LATCH] ? fLat_r : cmpRes;
    khz_nxt  = regs_r[REG_GPIO][GP_FAST] ? RDBK_FAST_KHZ : RDBK_SLOW_KHZ;
    // open drain: only ever pulls low
    pinOeN_nxt = 1'b1;
    if (rbOn) begin
      pinOeN_nxt = rdbkBit;
    end else if (role == ROLE_STATUS) begin
      pinOeN_nxt = !hostBlk;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_POR;
      regs_r       <= REG_RESET;
      storedRole_r <= ROLE_LOAD;
      latch_r      <= '0;
      code_r       <= '0;
      mrg_r        <= 2'h0;
      opOn_r       <= 1'b1;
      off_r        <= 1'b1;
      fLat_r       <= 2'h0;
      cmpO_r       <= 2'h0;
      stReq_r      <= 1'b0;
      rlReq_r      <= 1'b0;
      lock_r       <= 1'b0;
      spi_r        <= 1'b0;
      addr_r       <= I2C_ADDR_BASE;
      khz_r        <= RDBK_SLOW_KHZ;
      ans_r        <= '0;
      pinOeN_r     <= 1'b1;
      wDiv_r       <= 8'h00;
      phase_r      <= 12'h000;
      addrS1_r     <= 2'h0;
      addrS2_r     <= 2'h0;
      cmpS1_r      <= 2'h0;
      cmpS2_r      <= 2'h0;
    end else begin
      state_r      <= state_nxt;
      regs_r       <= regs_nxt;
      storedRole_r <= storedRole_nxt;
      latch_r      <= latch_nxt;
      code_r       <= code_nxt;
      mrg_r        <= mrg_nxt;
      opOn_r       <= opOn_nxt;
      off_r        <= off_nxt;
      fLat_r       <= fLat_nxt;
      cmpO_r       <= cmpO_nxt;
      stReq_r      <= stReq_nxt;
      rlReq_r      <= rlReq_nxt;
      lock_r       <= lock_nxt;
      spi_r        <= spi_nxt;
      addr_r       <= addr_nxt;
      khz_r        <= khz_nxt;
      ans_r        <= ans_nxt;
      pinOeN_r     <= pinOeN_nxt;
      wDiv_r       <= wDiv_nxt;
      phase_r      <= phase_nxt;
      addrS1_r     <= addrSelLevel;
      addrS2_r     <= addrS1_r;
      cmpS1_r      <= cmpRaw;
      cmpS2_r      <= cmpS1_r;
    end
  end

  assign hostAns      = ans_r;
  assign gpioPinOut   = 1'b0;
  assign gpioPinOeN   = pinOeN_r;
  assign nvmStoreReq  = stReq_r;
  assign nvmReloadReq = rlReq_r;
  assign regImage     = regs_r;
  assign dacCode0     = code_r[0];
  assign dacCode1     = code_r[1];
  assign outputsOff   = off_r;
  assign cmpOut       = cmpO_r;
  assign faultLatched = fLat_r;
  assign busy         = hostBlk;
  assign protoLocked  = lock_r;
  assign protoSpi     = spi_r;
  assign i2cAddr      = addr_r;
  assign rdbkMaxKhz   = khz_r;

  chk_load_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gpioFall && role == ROLE_LOAD && ldAll
    |=> latch_r[0] == $past(regs_r[REG_DAC0][11:0]))
    else $error("load trigger did not apply channel 0 code");
  chk_lock_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lock_r |=> lock_r && $stable(spi_r))
    else $error("protocol lock changed");
  chk_store_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_IDLE && regs_r[REG_TRIG][TR_STORE]
    |=> nvmStoreReq && !regs_r[REG_TRIG][TR_STORE] ##1 busy)
    else $error("store trigger not started and cleared");
  chk_busy_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostReq.valid && !hostDrop && hostBlk |=> hostAns.refused && !hostAns.ack)
    else $error("host access taken while busy");
  chk_spi_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostReq.valid && !hostReq.write && hostReq.spi && !rbOn |=> !hostAns.ack)
    else $error("spi read taken without readback role");
  chk_rdbk_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regs_r[REG_GPIO][GP_FAST] |=> rdbkMaxKhz == RDBK_FAST_KHZ)
    else $error("readback clock ceiling wrong");
  chk_shutdown_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    role == ROLE_SHUTDOWN && !gpioLevel |=> outputsOff)
    else $error("shutdown input ignored");
  chk_fault_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regs_r[REG_CMP][CP_LATCH] && cmpRes[0] |=> faultLatched[0] ##1 cmpOut[0])
    else $error("comparator trip not latched");
endmodule

// *** design/pin_qualifier.sv ***
`timescale 1ns/10ps
module pin_qualifier #(
  parameter int MIN_CYC = 20
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      fall
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CMAX = CW'(MIN_CYC - 1);

  logic          s1_r, s2_r, prev_r, lvl_r, fall_r;
  logic          lvl_nxt, fall_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  always_comb begin
    cnt_nxt  = (s2_r != prev_r) ? '0 : ((cnt_r >= CMAX) ? cnt_r : cnt_r + 1'b1);
    // a fall counts only after a high run of full length
    fall_nxt = prev_r & ~s2_r & (cnt_r >= CMAX);
    lvl_nxt  = ((s2_r == prev_r) && (cnt_r >= CMAX)) ? prev_r : lvl_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      prev_r <= 1'b1;
      lvl_r  <= 1'b1;
      fall_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      s1_r   <= pinIn;
      s2_r   <= s1_r;
      prev_r <= s2_r;
      lvl_r  <= lvl_nxt;
      fall_r <= fall_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign level = lvl_r;
  assign fall  = fall_r;
endmodule

// *** sim/dac_host_port_and_gpio_load_tb.sv ***
`timescale 1ns/10ps
module dac_host_port_and_gpio_load_tb
  import dac_front_pkg::*;
;
  logic                  sys_clk = 1'b0;
  logic                  rst_n;
  hostReq_s              hostReq;
  hostAns_s              hostAns;
  hostAns_s              ans;
  logic                  tbPinLow;
  logic                  gpioPinIn;
  logic                  gpioPinOeN;
  logic [1:0]            addrSel;
  logic [NREG-1:0][15:0] nvmImage;
  logic [NREG-1:0][15:0] initImage;
  logic [NREG-1:0][15:0] regImage;
  logic                  nvmImageValid;
  logic                  nvmDone;
  logic                  nvmStoreReq;
  logic                  nvmReloadReq;
  logic                  busy;
  logic                  protoLocked;
  logic                  protoSpi;
  logic                  outputsOff;
  logic [11:0]           dacCode0;
  logic [11:0]           dacCode1;
  logic [11:0]           c0;
  logic [11:0]           c1;
  logic [11:0]           n0;
  logic [11:0]           n1;
  logic [6:0]            i2cAddr;
  logic [3:0]            a;
  logic [1:0]            cmp;
  logic [1:0]            cmpO;
  logic [1:0]            faultLat;
  logic [11:0]           khz;
  logic [7:0]            opVal [4] = '{8'h00, 8'h80, 8'h90, 8'hA0};
  int                    num_errors = 0;
  int                    check_count = 0;

  always #50 sys_clk = ~sys_clk;
  // pulled-up open-drain pin
  assign gpioPinIn = ~tbPinLow & gpioPinOeN;

  dac_host_port_and_gpio_load #(.GPI_MIN(3)) dac_host_port_and_gpio_load_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .hostReq(hostReq), .hostAns(hostAns),
    .gpioPinIn(gpioPinIn), .gpioPinOut(), .gpioPinOeN(gpioPinOeN),
    .addrSelLevel(addrSel), .cmpRaw(cmp), .rdbkBit(1'b0), .nvmImage(nvmImage),
    .nvmImageValid(nvmImageValid), .nvmDone(nvmDone), .nvmStoreReq(nvmStoreReq),
    .nvmReloadReq(nvmReloadReq), .regImage(regImage), .dacCode0(dacCode0),
    .dacCode1(dacCode1), .outputsOff(outputsOff), .cmpOut(cmpO), .faultLatched(faultLat),
    .busy(busy), .protoLocked(protoLocked), .protoSpi(protoSpi),
    .i2cAddr(i2cAddr), .rdbkMaxKhz(khz));

  nvm_model nvm_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .nvmStoreReq(nvmStoreReq),
    .nvmReloadReq(nvmReloadReq), .regImage(regImage), .initImage(initImage),
    .nvmImage(nvmImage), .nvmImageValid(nvmImageValid), .nvmDone(nvmDone));

  function automatic logic [6:0] exp_addr(input logic [1:0] lvl);
    return I2C_ADDR_BASE + {5'h0, lvl};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // request taken at the next edge; the registered answer stands just after it
  task automatic req(input logic w, input logic s, input logic p,
                     input logic [3:0] adr, input logic [15:0] d);
    @(posedge sys_clk);
    hostReq <= '{1'b1, w, s, p, adr, d};
    @(posedge sys_clk);
    hostReq.valid <= 1'b0;
    #1 ans = hostAns;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [15:0] d);
    req(1'b1, 1'b0, 1'b0, adr, d);
    check({15'h0, ans.ack}, 16'h1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check({15'h0, busy}, 16'h0);
  endtask

  task automatic load_fall(input logic [11:0] e0, input logic [11:0] e1);
    int n;
    @(posedge sys_clk);
    tbPinLow <= 1'b0;
    // holds the pin high well past the qualifier minimum before the fall
    repeat (12) @(posedge sys_clk);
    tbPinLow <= 1'b1;
    n = 0;
    while (!(dacCode0 === e0 && dacCode1 === e1) && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check({15'h0, n <= LOAD_MAX_CYC}, 16'h1);
    check({4'h0, dacCode0}, {4'h0, e0});
    check({4'h0, dacCode1}, {4'h0, e1});
    repeat (22) @(posedge sys_clk);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    hostReq = '0;
    tbPinLow = 1'b0;
    cmp = 2'h0;
    rst_n = 1'b0;
    void'($urandom(32'h5ad2260f));
    addrSel = 2'($urandom);
    initImage = REG_RESET;
    initImage[0] = {4'h0, 12'($urandom)};
    initImage[1] = {4'h0, 12'($urandom)};
    c0 = initImage[0][11:0];
    c1 = initImage[1][11:0];
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_idle();
    for (int i = 0; i < NREG; i++) check(regImage[i], initImage[i]);
    check({9'h0, i2cAddr}, {9'h0, exp_addr(addrSel)});
    check({4'h0, khz}, {4'h0, RDBK_SLOW_KHZ});
    end_test("power-on load");
    for (int i = 0; i < 8; i++) begin
      a = 4'($urandom_range(1));
      n0 = 12'($urandom);
      wr(a, {4'h0, n0});
      req(1'b0, 1'b0, 1'b0, a, 16'h0);
      check(ans.rdata, {4'h0, n0});
      if (a == 4'h0) c0 = n0;
      else c1 = n0;
    end
    check({14'h0, protoLocked, protoSpi}, 16'h2);
    req(1'b1, 1'b1, 1'b0, REG_DAC0, 16'h0ABC);
    check({14'h0, ans.ack, ans.refused}, 16'h0);
    check(regImage[REG_DAC0], {4'h0, c0});
    req(1'b0, 1'b0, 1'b0, 4'hC, 16'h0);
    check(ans.rdata, 16'h0);
    end_test("register traffic and lock");
    load_fall(c0, c1);
    n0 = 12'($urandom);
    wr(REG_DAC0, {4'h0, n0});
    @(posedge sys_clk);
    tbPinLow <= 1'b0;
    @(posedge sys_clk);
    tbPinLow <= 1'b1;
    repeat (30) @(posedge sys_clk);
    #1 check({4'h0, dacCode0}, {4'h0, c0});
    load_fall(n0, c1);
    c0 = n0;
    end_test("load all and glitch");
    wr(REG_GPIO, 16'h0010);
    n0 = 12'($urandom);
    n1 = 12'($urandom);
    wr(REG_DAC0, {4'h0, n0});
    wr(REG_DAC1, {4'h0, n1});
    load_fall(c0, n1);
    wr(REG_GPIO, 16'h0000);
    load_fall(n0, n1);
    c0 = n0;
    c1 = n1;
    end_test("single channel load");
    wr(REG_MRG_HI, {4'h0, ~c0});
    foreach (opVal[k]) begin
      n0[7:0] = opVal[k];
      req(1'b1, 1'b0, 1'b1, 4'h0, {PMB_OPERATION, n0[7:0]});
      repeat (3) @(posedge sys_clk);
      #1 check({14'h0, ans.ack, outputsOff}, {14'h0, 1'b1, ~n0[7]});
    end
    check({4'h0, dacCode0}, {4'h0, ~c0});
    end_test("operation command");
    wr(REG_TRIG, 16'h0001);
    n1 = 12'h0;
    for (int i = 0; i < 4 && n1 == 12'h0; i++) begin
      @(posedge sys_clk);
      #1 if (nvmStoreReq === 1'b1) n1 = 12'h1;
    end
    check({4'h0, n1}, 16'h1);
    @(posedge sys_clk);
    #1 check({14'h0, regImage[REG_TRIG][TR_STORE], busy}, 16'h1);
    req(1'b1, 1'b0, 1'b0, REG_DAC0, 16'h0123);
    check({14'h0, ans.ack, ans.refused}, 16'h1);
    wait_idle();
    check(regImage[REG_DAC0], {4'h0, c0});
    wr(REG_DAC0, {4'h0, ~c0});
    wr(REG_TRIG, 16'h0002);
    repeat (3) @(posedge sys_clk);
    wait_idle();
    check(regImage[REG_DAC0], {4'h0, c0});
    end_test("store and reload");
    wr(REG_CMP, 16'h0010);
    @(posedge sys_clk);
    cmp <= 2'h1;
    repeat (4) @(posedge sys_clk);
    cmp <= 2'h0;
    repeat (4) @(posedge sys_clk);
    #1 check({12'h0, faultLat, cmpO}, 16'h0005);
    wr(REG_TRIG, 16'h0004);
    repeat (2) @(posedge sys_clk);
    #1 check({12'h0, faultLat, cmpO}, 16'h0000);
    wr(REG_GPIO, 16'h0028);
    @(posedge sys_clk);
    #1 check({4'h0, khz}, {4'h0, RDBK_FAST_KHZ});
    end_test("comparator latch and readback rate");
    stop_test();
  end
endmodule

// *** sim/nvm_model.sv ***
`timescale 1ns/10ps
module nvm_model
  import dac_front_pkg::*;
#(
  parameter int DONE_CYC = 40
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  nvmStoreReq,
  input  wire logic                  nvmReloadReq,
  input  wire logic [NREG-1:0][15:0] regImage,
  input  wire logic [NREG-1:0][15:0] initImage,
  output logic [NREG-1:0][15:0]      nvmImage,
  output logic                       nvmImageValid,
  output logic                       nvmDone
);
  logic [NREG-1:0][15:0] mem;
  int                    cnt;

  // contents outlive reset, like the real array
  initial #1 mem = initImage;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      nvmDone <= 1'b0;
    end else begin
      nvmDone <= (cnt == 1);
      if (nvmStoreReq || nvmReloadReq) begin
        cnt <= DONE_CYC;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      if (nvmStoreReq) begin
        mem <= regImage;
      end
    end
  end

  // image lines only meaningful with the done pulse; scrambled otherwise
  assign nvmImage      = nvmDone ? mem : ~mem;
  assign nvmImageValid = 1'b1;
endmodule
